// *** hdl/nvm_regs.svh ***
// Register offsets, field positions, reset values and timing counts
//
// Overview of operation
// - Power-up reset clears write_permit so no write can start.
// - Data EEPROM writes are blocked while the 64 ms power-up timer runs.
// - Key 55h then AAh to unlock_key_port, then write_start, starts a write.
// - A write needs both the unlocked key sequence and write_permit set.
// - Program block write stalls the core until done; core resumes at 3rd instruction.
// - Data protect fuse at '0' denies external-path data EEPROM access.
// - Write end clears write_start and sets sticky nv_done_flag.
// - write_start cannot be set without write_permit; clearing it never aborts.
// - Program write at low bits 111 erases eight words, programs eight; others load buffer.
// - Program erase stalls the core about 4 ms; clocks keep running.
`ifndef NVM_REGS_SVH
`define NVM_REGS_SVH

// ==========================================================
// Register offsets
`define NVM_OFS_CTRL      4'h0
`define NVM_OFS_KEY       4'h1
`define NVM_OFS_ADDR_LOW  4'h2
`define NVM_OFS_ADDR_HIGH 4'h3
`define NVM_OFS_DATA_LOW  4'h4
`define NVM_OFS_DATA_HIGH 4'h5
`define NVM_OFS_IRQ_FLAG  4'h6
`define NVM_OFS_IRQ_EN    4'h7

// ==========================================================
// Field positions, masks and reset values
`define NVM_CTRL_SPACE    7
`define NVM_CTRL_FAULT    3
`define NVM_CTRL_PERMIT   2
`define NVM_CTRL_START    1
`define NVM_CTRL_READ     0
`define NVM_IRQ_DONE      4
`define NVM_ADDRH_MASK    8'h1f
`define NVM_DATAH_MASK    8'h3f
`define NVM_REG_RESET     8'h00
`define NVM_KEY_FIRST     8'h55
`define NVM_KEY_SECOND    8'haa
`define NVM_BLOCK_LAST    3'h7

// ==========================================================
// Timing
`define NVM_CLK_KHZ       25000
`define NVM_PWRT_MS       64
`define NVM_PWRT_CYC      (`NVM_PWRT_MS * `NVM_CLK_KHZ)
`define NVM_ERASE_MS      4
`define NVM_ERASE_CYC     (`NVM_ERASE_MS * `NVM_CLK_KHZ)
`define NVM_DWRITE_CYC    1024
`define NVM_PROG_CYC      64
`define NVM_TMR_W         21

`endif

// *** hdl/nvm_pkg.sv ***
// Types shared by the nonvolatile access controller
package nvm_pkg;

    // Operation sequencer states
    typedef enum logic [3:0] {
        NVM_ST_IDLE    = 4'b0001,
        NVM_ST_DWRITE  = 4'b0010,
        NVM_ST_ERASE   = 4'b0100,
        NVM_ST_PROGRAM = 4'b1000
    } nvm_state_t;

    // Unlock key sequence states
    typedef enum logic [2:0] {
        NVM_KEY_IDLE  = 3'b001,
        NVM_KEY_HALF  = 3'b010,
        NVM_KEY_ARMED = 3'b100
    } nvm_key_t;

endpackage

// *** hdl/nvm_if.sv ***
// Interfaces between the controller and its key sequencer and timers
`timescale 1ns/1ps
`default_nettype none

// Unlock key port traffic and armed status
interface nvm_key_if;
    logic       key_wr;
    logic [7:0] key_data;
    logic       other_wr;
    logic       armed;
    modport ctl (output key_wr, output key_data, output other_wr, input armed);
    modport seq (input key_wr, input key_data, input other_wr, output armed);
endinterface

// Down-counter load and status
interface nvm_tmr_if;
    logic        load;
    logic [20:0] value;
    logic        busy;
    logic        done;
    modport ctl (output load, output value, input busy, input done);
    modport tmr (input load, input value, output busy, output done);
endinterface

`default_nettype wire

// *** hdl/nvm_unlock.sv ***
// Unlock key sequencer: 55h then AAh with nothing in between
`timescale 1ns/1ps
`default_nettype none
`include "nvm_regs.svh"

module nvm_unlock (
    input  wire logic clk_i,
    input  wire logic rstn_i,
    nvm_key_if.seq    key
);
    nvm_pkg::nvm_key_t state;
    nvm_pkg::nvm_key_t next_state;

    // Any other register write breaks the order, the start write included
    always_comb begin
        next_state = state;
        if (key.other_wr) begin
            next_state = nvm_pkg::NVM_KEY_IDLE;
        end else if (key.key_wr) begin
            if (key.key_data == `NVM_KEY_FIRST) begin
                next_state = nvm_pkg::NVM_KEY_HALF;
            end else if (state == nvm_pkg::NVM_KEY_HALF && key.key_data == `NVM_KEY_SECOND) begin
                next_state = nvm_pkg::NVM_KEY_ARMED;
            end else begin
                next_state = nvm_pkg::NVM_KEY_IDLE;
            end
        end
    end

    // Sequence state
    always_ff @(posedge clk_i) begin
        if (!rstn_i) state <= nvm_pkg::NVM_KEY_IDLE;
        else         state <= next_state;
    end

    assign key.armed = (state == nvm_pkg::NVM_KEY_ARMED);

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    AST_KEY_ARM: assert property (state == nvm_pkg::NVM_KEY_HALF && key.key_wr && key.key_data == `NVM_KEY_SECOND && !key.other_wr |=> key.armed)
        else $error("Key pair did not arm");
    AST_KEY_BREAK: assert property (key.key_wr && key.key_data != `NVM_KEY_FIRST && state != nvm_pkg::NVM_KEY_HALF |=> !key.armed ##1 !key.armed || key.key_wr)
        else $error("Broken key order left sequence armed");
endmodule

`default_nettype wire

// *** hdl/nvm_timer.sv ***
// Loadable down-counter; done pulses on its last counted cycle
`timescale 1ns/1ps
`default_nettype none

module nvm_timer (
    input  wire logic clk_i,
    input  wire logic rstn_i,
    nvm_tmr_if.tmr    t
);
    logic [20:0] cnt;

    // Count down to zero; a load restarts the count
    always_ff @(posedge clk_i) begin
        if (!rstn_i)         cnt <= 21'h0;
        else if (t.load)     cnt <= t.value;
        else if (cnt != 0)   cnt <= cnt - 21'h1;
    end

    assign t.busy = (cnt != 21'h0);
    // Done reads only the count: the sequencer reloads from it, so no loop through load
    assign t.done = (cnt == 21'h1);
endmodule

`default_nettype wire

// *** hdl/nvm_ctrl.sv ***
// Nonvolatile memory self-write controller: registers, key guard, sequencer
`timescale 1ns/1ps
`default_nettype none
`include "nvm_regs.svh"

module nvm_ctrl #(
    parameter int unsigned PWRT_CYCLES   = `NVM_PWRT_CYC,
    parameter int unsigned ERASE_CYCLES  = `NVM_ERASE_CYC,
    parameter int unsigned DWRITE_CYCLES = `NVM_DWRITE_CYC,
    parameter int unsigned PROG_CYCLES   = `NVM_PROG_CYC
) (
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    input  wire logic [3:0]  addr_i,
    input  wire logic [7:0]  wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [7:0]  rdata_o,
    output logic             irq_o,
    output logic             core_stall_o,
    input  wire logic        data_protect_fuse_i,
    output logic             ext_data_access_o,
    output logic      [12:0] mem_addr_o,
    output logic      [13:0] mem_wdata_o,
    input  wire logic [13:0] mem_rdata_i,
    output logic             mem_space_o,
    output logic             mem_read_o,
    output logic             mem_buf_load_o,
    output logic             mem_data_write_o,
    output logic             mem_erase_o,
    output logic             mem_program_o
);
    // ==========================================================
    // Load values for the timers
    localparam logic [20:0] PWRT_LD   = 21'(PWRT_CYCLES);
    localparam logic [20:0] ERASE_LD  = 21'(ERASE_CYCLES);
    localparam logic [20:0] DWRITE_LD = 21'(DWRITE_CYCLES);
    localparam logic [20:0] PROG_LD   = 21'(PROG_CYCLES);

    // ==========================================================
    // Registers and internal signals
    logic [7:0]          addr_low;
    logic [7:0]          addr_high;
    logic [7:0]          data_low;
    logic [7:0]          data_high;
    logic                program_space_select;
    logic                write_fault_flag;
    logic                write_permit;
    logic                write_start;
    logic                nv_done_flag;
    logic                nv_done_irq_enable;
    logic                pwrt_started;
    logic                pwrt_done;
    logic                fuse_s1;
    logic                fuse_s2;
    logic                read_pending;
    nvm_pkg::nvm_state_t state;
    nvm_pkg::nvm_state_t next_state;
    logic                wr_ctrl;
    logic                start_req;
    logic                go;
    logic                block_last;
    logic                finish;
    logic                buf_load_now;
    logic                read_req;

    nvm_key_if key ();
    nvm_tmr_if pwrt ();
    nvm_tmr_if op ();

    nvm_unlock u_unlock (
        .clk_i  (clk_i),
        .rstn_i (rstn_i),
        .key    (key.seq)
    );

    nvm_timer u_pwrt (
        .clk_i  (clk_i),
        .rstn_i (rstn_i),
        .t      (pwrt.tmr)
    );

    nvm_timer u_op (
        .clk_i  (clk_i),
        .rstn_i (rstn_i),
        .t      (op.tmr)
    );

    // ==========================================================
    // Bus decode and key sequencer feed
    assign wr_ctrl      = wr_i && (addr_i == `NVM_OFS_CTRL);
    assign key.key_wr   = wr_i && (addr_i == `NVM_OFS_KEY);
    assign key.key_data = wdata_i;
    assign key.other_wr = wr_i && (addr_i != `NVM_OFS_KEY);
    assign read_req     = wr_ctrl && wdata_i[`NVM_CTRL_READ] && (state == nvm_pkg::NVM_ST_IDLE);

    // Start needs an idle sequencer, permit already set and the armed key
    assign start_req  = wr_ctrl && wdata_i[`NVM_CTRL_START] && (state == nvm_pkg::NVM_ST_IDLE);
    assign go         = start_req && write_permit && key.armed
                        && (wdata_i[`NVM_CTRL_SPACE] || pwrt_done);
    assign block_last = (addr_low[2:0] == `NVM_BLOCK_LAST);
    assign buf_load_now = go && wdata_i[`NVM_CTRL_SPACE] && !block_last;

    // ==========================================================
    // Power-up timer: starts right after reset release
    always_ff @(posedge clk_i) begin
        if (!rstn_i) pwrt_started <= 1'b0;
        else         pwrt_started <= 1'b1;
    end

    assign pwrt.load  = !pwrt_started;
    assign pwrt.value = PWRT_LD;
    assign pwrt_done  = pwrt_started && !pwrt.busy;

    // ==========================================================
    // Operation sequencer
    always_comb begin
        next_state = state;
        op.load    = 1'b0;
        op.value   = DWRITE_LD;
        finish     = buf_load_now;
        unique case (state)
            nvm_pkg::NVM_ST_IDLE: begin
                if (go && !wdata_i[`NVM_CTRL_SPACE]) begin
                    next_state = nvm_pkg::NVM_ST_DWRITE;
                    op.load    = 1'b1;
                end else if (go && block_last) begin
                    next_state = nvm_pkg::NVM_ST_ERASE;
                    op.load    = 1'b1;
                    op.value   = ERASE_LD;
                end
            end
            nvm_pkg::NVM_ST_DWRITE: begin
                if (op.done) begin
                    next_state = nvm_pkg::NVM_ST_IDLE;
                    finish     = 1'b1;
                end
            end
            nvm_pkg::NVM_ST_ERASE: begin
                if (op.done) begin
                    next_state = nvm_pkg::NVM_ST_PROGRAM;
                    op.load    = 1'b1;
                    op.value   = PROG_LD;
                end
            end
            nvm_pkg::NVM_ST_PROGRAM: begin
                if (op.done) begin
                    next_state = nvm_pkg::NVM_ST_IDLE;
                    finish     = 1'b1;
                end
            end
            default: begin
                next_state = nvm_pkg::NVM_ST_IDLE;
            end
        endcase
    end

    // Sequencer state; clearing permit mid-write does not abort
    always_ff @(posedge clk_i) begin
        if (!rstn_i) state <= nvm_pkg::NVM_ST_IDLE;
        else         state <= next_state;
    end

    // The core halts for the whole block erase and program
    assign core_stall_o     = (state == nvm_pkg::NVM_ST_ERASE)
                              || (state == nvm_pkg::NVM_ST_PROGRAM);
    assign mem_data_write_o = (state == nvm_pkg::NVM_ST_DWRITE);
    assign mem_erase_o      = (state == nvm_pkg::NVM_ST_ERASE);
    assign mem_program_o    = (state == nvm_pkg::NVM_ST_PROGRAM);

    // ==========================================================
    // Control bits
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            write_permit         <= 1'b0;
            write_start          <= 1'b0;
            program_space_select <= 1'b0;
        end else begin
            if (wr_ctrl) write_permit <= wdata_i[`NVM_CTRL_PERMIT];
            if (wr_ctrl && state == nvm_pkg::NVM_ST_IDLE) begin
                program_space_select <= wdata_i[`NVM_CTRL_SPACE];
            end
            // Buffer loads finish at once and never show as busy
            if (finish)                     write_start <= 1'b0;
            else if (go && !buf_load_now)   write_start <= 1'b1;
        end
    end

    // Fault survives reset: a reset during a write sets it, software clears it
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            if (state != nvm_pkg::NVM_ST_IDLE) write_fault_flag <= 1'b1;
        end else if (wr_ctrl) begin
            write_fault_flag <= wdata_i[`NVM_CTRL_FAULT];
        end
    end

    // ==========================================================
    // Address and data registers; a read result overrides a same-cycle write
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            addr_low  <= `NVM_REG_RESET;
            addr_high <= `NVM_REG_RESET;
            data_low  <= `NVM_REG_RESET;
            data_high <= `NVM_REG_RESET;
        end else begin
            if (wr_i && addr_i == `NVM_OFS_ADDR_LOW)  addr_low  <= wdata_i;
            if (wr_i && addr_i == `NVM_OFS_ADDR_HIGH) addr_high <= wdata_i & `NVM_ADDRH_MASK;
            if (read_pending) begin
                data_low  <= mem_rdata_i[7:0];
                data_high <= {2'h0, mem_rdata_i[13:8]};
            end else begin
                if (wr_i && addr_i == `NVM_OFS_DATA_LOW)  data_low  <= wdata_i;
                if (wr_i && addr_i == `NVM_OFS_DATA_HIGH) data_high <= wdata_i & `NVM_DATAH_MASK;
            end
        end
    end

    // ==========================================================
    // Array port: address and data latched when an access starts
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            mem_addr_o     <= 13'h0;
            mem_wdata_o    <= 14'h0;
            mem_space_o    <= 1'b0;
            mem_read_o     <= 1'b0;
            mem_buf_load_o <= 1'b0;
            read_pending   <= 1'b0;
        end else begin
            if (go || read_req) begin
                mem_addr_o  <= {addr_high[4:0], addr_low};
                mem_wdata_o <= {data_high[5:0], data_low};
                mem_space_o <= wdata_i[`NVM_CTRL_SPACE];
            end
            mem_read_o     <= read_req;
            read_pending   <= read_req;
            mem_buf_load_o <= buf_load_now;
        end
    end

    // ==========================================================
    // Data protect fuse: external path only sees data memory when it is 1
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            fuse_s1           <= 1'b0;
            fuse_s2           <= 1'b0;
            ext_data_access_o <= 1'b0;
        end else begin
            fuse_s1           <= data_protect_fuse_i;
            fuse_s2           <= fuse_s1;
            ext_data_access_o <= fuse_s2;
        end
    end

    // ==========================================================
    // Completion interrupt: set wins over a write-one clear
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            nv_done_flag       <= 1'b0;
            nv_done_irq_enable <= 1'b0;
        end else begin
            if (finish) begin
                nv_done_flag <= 1'b1;
            end else if (wr_i && addr_i == `NVM_OFS_IRQ_FLAG && wdata_i[`NVM_IRQ_DONE]) begin
                nv_done_flag <= 1'b0;
            end
            if (wr_i && addr_i == `NVM_OFS_IRQ_EN) begin
                nv_done_irq_enable <= wdata_i[`NVM_IRQ_DONE];
            end
        end
    end

    assign irq_o = nv_done_flag && nv_done_irq_enable;

    // ==========================================================
    // Read data, valid only in the cycle after the read strobe
    always_ff @(posedge clk_i) begin
        if (!rstn_i || !rd_i) begin
            rdata_o <= 8'h00;
        end else begin
            unique case (addr_i)
                `NVM_OFS_CTRL:      rdata_o <= {program_space_select, 3'h0, write_fault_flag,
                                                write_permit, write_start, 1'b0};
                `NVM_OFS_ADDR_LOW:  rdata_o <= addr_low;
                `NVM_OFS_ADDR_HIGH: rdata_o <= addr_high;
                `NVM_OFS_DATA_LOW:  rdata_o <= data_low;
                `NVM_OFS_DATA_HIGH: rdata_o <= data_high;
                `NVM_OFS_IRQ_FLAG:  rdata_o <= {3'h0, nv_done_flag, 4'h0};
                `NVM_OFS_IRQ_EN:    rdata_o <= {3'h0, nv_done_irq_enable, 4'h0};
                default:            rdata_o <= 8'h00;
            endcase
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    AST_PERMIT_CLEAR: assert property ($rose(rstn_i) |-> !write_permit && !write_start)
        else $error("Write permit set after reset");
    AST_PWRT_BLOCK: assert property ($rose(mem_data_write_o) |-> $past(pwrt_done))
        else $error("Data write started during power-up timer");
    AST_KEY_ORDER: assert property ($rose(write_start) |-> $past(key.armed))
        else $error("Write started without unlock keys");
    AST_PERMIT_GUARD: assert property ($rose(write_start) |-> $past(write_permit))
        else $error("Write started without write permit");
    AST_NO_ABORT: assert property (mem_erase_o && !write_permit && !op.done |=> mem_erase_o)
        else $error("Clearing permit aborted the erase");
    AST_STALL_BLOCK: assert property ($rose(mem_erase_o) |-> core_stall_o [*8])
        else $error("Core not stalled during block erase");
    AST_ERASE_LAST: assert property ($rose(mem_erase_o) |-> mem_addr_o[2:0] == 3'h7 ##0 mem_space_o)
        else $error("Erase started off the last word of a block");
    AST_DONE_FLAG: assert property ($fell(write_start) && rstn_i |-> nv_done_flag && state == nvm_pkg::NVM_ST_IDLE)
        else $error("Write end without done flag");
    AST_FUSE_DENY: assert property (ext_data_access_o |-> $past(data_protect_fuse_i, 3))
        else $error("External data access granted while protected");
endmodule

`default_nettype wire

// *** test/nvm_ctrl_tb.sv ***
// Self-checking testbench for the nonvolatile self-write controller
`timescale 1ns/1ps
`default_nettype none
`include "nvm_regs.svh"

module nvm_ctrl_tb;
    // ==========================================================
    // Shortened counts so the power-up, erase and write waits stay brief
    localparam int unsigned PWRT = 64;
    localparam int unsigned ERAS = 16;
    localparam int unsigned DWR  = 8;
    localparam int unsigned PROG = 4;

    logic        clk_i;
    logic        rstn_i;
    logic [3:0]  addr_i;
    logic [7:0]  wdata_i;
    logic        wr_i;
    logic        rd_i;
    logic [7:0]  rdata_o;
    logic        irq_o;
    logic        core_stall_o;
    logic        fuse;
    logic        ext_o;
    logic [12:0] mem_addr_o;
    logic [13:0] mem_wdata_o;
    logic [13:0] mem_rdata_i;
    logic        mem_space_o;
    logic        mem_read_o;
    logic        mem_buf_load_o;
    logic        mem_data_write_o;
    logic        mem_erase_o;
    logic        mem_program_o;
    int          err_count;
    int          compares;
    int          n;
    int          ne;
    int          np;

    nvm_ctrl #(.PWRT_CYCLES(PWRT), .ERASE_CYCLES(ERAS), .DWRITE_CYCLES(DWR),
               .PROG_CYCLES(PROG)) nvm_ctrl_i (
        .clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o),
        .core_stall_o(core_stall_o), .data_protect_fuse_i(fuse),
        .ext_data_access_o(ext_o), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
        .mem_rdata_i(mem_rdata_i), .mem_space_o(mem_space_o), .mem_read_o(mem_read_o),
        .mem_buf_load_o(mem_buf_load_o), .mem_data_write_o(mem_data_write_o),
        .mem_erase_o(mem_erase_o), .mem_program_o(mem_program_o));

    // ==========================================================
    // Clock at 25 MHz
    always begin
        #20 clk_i = ~clk_i;
    end

    // Compare and count; unknowns never match
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // One-cycle write; the idle cycle before it keeps strobes from colliding
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i    <= 1'b0;
    endtask

    // Read data is only valid in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] exp);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i   <= 1'b0;
        #1;
        chk("rdata", {8'h00, exp}, {8'h00, rdata_o & m});
    endtask

    // Key sequence then control write; ends on the edge that takes the start
    task automatic start(input logic [7:0] c);
        wr(`NVM_OFS_KEY, `NVM_KEY_FIRST);
        wr(`NVM_OFS_KEY, `NVM_KEY_SECOND);
        wr(`NVM_OFS_CTRL, c);
        #1;
    endtask

    // Counts cycles a busy level stands high, with a bound against hangs
    task automatic count_busy(input bit prog);
        n  = 0;
        ne = 0;
        np = 0;
        while (((prog ? core_stall_o : mem_data_write_o) === 1'b1) && n < 300) begin
            if (mem_erase_o === 1'b1) ne++;
            if (mem_program_o === 1'b1) np++;
            n++;
            @(posedge clk_i);
            #1;
        end
    endtask

    task automatic reset_dut(input int cyc);
        @(posedge clk_i);
        rstn_i <= 1'b0;
        repeat (cyc) @(posedge clk_i);
        rstn_i <= 1'b1;
    endtask

    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ==========================================================
    // Watchdog: the whole sequence needs well under a thousand cycles
    initial begin
        #(40 * 5000);
        err_count++;
        give_verdict();
    end

    // ==========================================================
    // Main sequence
    initial begin
        clk_i = 1'b0; rstn_i = 1'b0; addr_i = 4'h0; wdata_i = 8'h00; wr_i = 1'b0;
        rd_i = 1'b0; fuse = 1'b1; mem_rdata_i = 14'h0000; err_count = 0; compares = 0;
        reset_dut(5);
        // Reset values; fault bit is undefined at power-on so it is masked
        rd(`NVM_OFS_CTRL, 8'hf7, 8'h00);
        for (int a = 1; a < 8; a++) rd(a[3:0], 8'hff, 8'h00);
        rd(4'h9, 8'hff, 8'h00);
        // Permit set, but the power-up timer still blocks data writes
        wr(`NVM_OFS_CTRL, 8'h04);
        start(8'h06);
        chk("dwrite_early", 16'h0, {15'h0, mem_data_write_o});
        repeat (PWRT) @(posedge clk_i);
        // Start refused while permit was clear before the write
        wr(`NVM_OFS_CTRL, 8'h00);
        start(8'h06);
        chk("dwrite_nopermit", 16'h0, {15'h0, mem_data_write_o});
        // Broken key orders: intervening write, swapped keys, wrong value
        wr(`NVM_OFS_KEY, 8'h55); wr(`NVM_OFS_ADDR_LOW, 8'h00); wr(`NVM_OFS_KEY, 8'haa);
        wr(`NVM_OFS_CTRL, 8'h06); #1;
        chk("disarm_other", 16'h0, {15'h0, mem_data_write_o});
        wr(`NVM_OFS_KEY, 8'haa); wr(`NVM_OFS_KEY, 8'h55); wr(`NVM_OFS_CTRL, 8'h06); #1;
        chk("disarm_swap", 16'h0, {15'h0, mem_data_write_o});
        wr(`NVM_OFS_KEY, 8'h55); wr(`NVM_OFS_KEY, 8'h56); wr(`NVM_OFS_KEY, 8'haa);
        wr(`NVM_OFS_CTRL, 8'h06); #1;
        chk("disarm_value", 16'h0, {15'h0, mem_data_write_o});
        // Proper data write; clearing permit meanwhile must not abort it
        wr(`NVM_OFS_ADDR_LOW, 8'h5a); wr(`NVM_OFS_ADDR_HIGH, 8'hff);
        wr(`NVM_OFS_DATA_LOW, 8'hc3); wr(`NVM_OFS_DATA_HIGH, 8'hff);
        rd(`NVM_OFS_ADDR_HIGH, 8'hff, 8'h1f);
        rd(`NVM_OFS_DATA_HIGH, 8'hff, 8'h3f);
        wr(`NVM_OFS_IRQ_EN, 8'h10);
        start(8'h06);
        chk("dwrite_go", 16'h1, {15'h0, mem_data_write_o});
        chk("mem_addr", 16'h1f5a, {3'h0, mem_addr_o});
        chk("mem_wdata", 16'h3fc3, {2'h0, mem_wdata_o});
        rd(`NVM_OFS_CTRL, 8'h02, 8'h02);
        wr(`NVM_OFS_CTRL, 8'h00); #1;
        count_busy(1'b0);
        chk("dwrite_len", DWR[15:0] - 16'd4, n[15:0]);
        rd(`NVM_OFS_CTRL, 8'h06, 8'h00);
        rd(`NVM_OFS_IRQ_FLAG, 8'hff, 8'h10);
        chk("irq_on", 16'h1, {15'h0, irq_o});
        wr(`NVM_OFS_IRQ_EN, 8'h00); #1;
        chk("irq_masked", 16'h0, {15'h0, irq_o});
        rd(`NVM_OFS_IRQ_FLAG, 8'hff, 8'h10);
        wr(`NVM_OFS_IRQ_EN, 8'h10); wr(`NVM_OFS_IRQ_FLAG, 8'h10); #1;
        chk("irq_cleared", 16'h0, {15'h0, irq_o});
        rd(`NVM_OFS_IRQ_FLAG, 8'hff, 8'h00);
        // Program word that only loads the buffer: no stall, done set
        wr(`NVM_OFS_CTRL, 8'h04); wr(`NVM_OFS_ADDR_LOW, 8'h03);
        start(8'h86);
        chk("buf_load", 16'h1, {15'h0, mem_buf_load_o});
        chk("no_stall", 16'h0, {15'h0, core_stall_o});
        rd(`NVM_OFS_IRQ_FLAG, 8'hff, 8'h10);
        wr(`NVM_OFS_IRQ_FLAG, 8'h10);
        // Last word of the block: erase then program, core held over both
        wr(`NVM_OFS_CTRL, 8'h04); wr(`NVM_OFS_ADDR_LOW, 8'h07);
        start(8'h86);
        chk("space", 16'h1, {15'h0, mem_space_o});
        // Permit dropped two cycles into the erase; the block must still finish
        wr(`NVM_OFS_CTRL, 8'h80); #1;
        count_busy(1'b1);
        chk("stall_len", ERAS[15:0] + PROG[15:0] - 16'd2, n[15:0]);
        chk("erase_len", ERAS[15:0] - 16'd2, ne[15:0]);
        chk("prog_len", PROG[15:0], np[15:0]);
        rd(`NVM_OFS_CTRL, 8'h86, 8'h80);
        rd(`NVM_OFS_IRQ_FLAG, 8'hff, 8'h10);
        wr(`NVM_OFS_IRQ_FLAG, 8'h10);
        // Array read loads the data pair
        mem_rdata_i <= 14'h1abc;
        wr(`NVM_OFS_CTRL, 8'h01); #1;
        chk("mem_read", 16'h1, {15'h0, mem_read_o});
        chk("read_addr", 16'h1f07, {3'h0, mem_addr_o});
        chk("read_space", 16'h0, {15'h0, mem_space_o});
        // Software read-back verify; an array refresh repeats this per byte
        rd(`NVM_OFS_DATA_LOW, 8'hff, 8'hbc);
        rd(`NVM_OFS_DATA_HIGH, 8'hff, 8'h1a);
        // Protect fuse follows through the synchroniser
        fuse <= 1'b0; repeat (4) @(posedge clk_i); #1;
        chk("ext_blocked", 16'h0, {15'h0, ext_o});
        fuse <= 1'b1; repeat (4) @(posedge clk_i); #1;
        chk("ext_open", 16'h1, {15'h0, ext_o});
        // Reset in mid-write leaves the fault bit set and permit clear
        wr(`NVM_OFS_CTRL, 8'h04);
        start(8'h06);
        reset_dut(2);
        rd(`NVM_OFS_CTRL, 8'h0e, 8'h08);
        wr(`NVM_OFS_CTRL, 8'h00);
        rd(`NVM_OFS_CTRL, 8'h0e, 8'h00);
        give_verdict();
    end
endmodule

`default_nettype wire
